/* fabric_sink.sv */
// fabric-side consumer that captures each receive word
`timescale 1ns/10ps
module fabric_sink (
	input wire logic ref_clk, rx_valid, full_flag, empty_flag,
	input wire logic [63:0] rx_data,
	output logic got,
	output logic [65:0] seen);
	// capture every rising edge; got marks a qualified word
	always_ff @(posedge ref_clk) begin
		got <= rx_valid;
		seen <= {full_flag, empty_flag, rx_data};
	end
endmodule : fabric_sink

/* rate_match_defines.svh */
// constants for the rate-match status mapping block
`ifndef RATE_MATCH_DEFINES_SVH
`define RATE_MATCH_DEFINES_SVH

// status codes on the two-bit status pair
`define RM_CODE_NONE       2'h0
`define RM_CODE_DELETE     2'h1
`define RM_CODE_INSERT     2'h2
`define RM_CODE_EMPTY      2'h2
`define RM_CODE_FULL       2'h3

// 9-bit control characters (control bit at bit 8)
`define RM_PAD_CHAR        9'h1F7
`define RM_BAD_END_CHAR    9'h1FE

// status pair positions within each 16-bit slice of the receive bus
`define RM_SLICE_WIDTH     16
`define RM_PAIR_LSB        13
`define RM_CHAR_WIDTH      9
`define RM_CODE_WIDTH      2

// slice indices for the fixed pairs of the other protocols
`define RM_NARROW_SLICE    0
`define RM_WIDE_SLICE      2

`endif

/* rate_match_pkg.sv */
// types shared by the rate-match status mapping block
package rate_match_pkg;

	// protocol family selecting how status is reported
	typedef enum logic [1:0] {
		proto_coded_dw = 2'h0,	// pcie pipe, basic double width
		proto_flag_dw  = 2'h1,	// xaui, gige, serial rapidio double width
		proto_other    = 2'h2	// all other protocols
	} proto_type;

endpackage : rate_match_pkg

/* rate_match_slice.sv */
// one 16-bit receive slice with its status pair merged in
`timescale 1ns/10ps
`include "rate_match_defines.svh"

module rate_match_slice #(
	parameter int W = 16
) (
	// slice data
	input  wire logic [W-1:0] data_in,
	input  wire logic         put_code,
	input  wire logic [1:0]   code,
	// merged slice
	output logic      [W-1:0] data_out
);

	// overwrite the pair only when this slice carries status
	always_comb begin
		data_out = data_in;
		if (put_code) begin
			data_out[`RM_PAIR_LSB +: `RM_CODE_WIDTH] = code;
		end
	end

endmodule : rate_match_slice

/* rate_match_status_mapping.sv */
// rate-match status mapping onto the receive data bus
`timescale 1ns/10ps
`include "rate_match_defines.svh"

module rate_match_status_mapping #(
	parameter int DATA_W   = 64,
	parameter int SLICES   = 4
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     arst_n,
	input  wire logic                     clk_en,
	// configuration
	input  wire logic                     simple_if_en,
	input  wire logic                     status_en,
	input  wire rate_match_pkg::proto_type proto,
	input  wire logic                     wide_fabric,
	input  wire logic [1:0]               status_slice,
	input  wire logic                     empty_use_bad_end,
	// receive word from the pcs, with buffer events
	input  wire logic [DATA_W-1:0]        pcs_data,
	input  wire logic                     pcs_valid,
	input  wire logic                     buf_full,
	input  wire logic                     buf_empty,
	input  wire logic                     buf_insert,
	input  wire logic                     buf_delete,
	// receive word to the fabric
	output logic      [DATA_W-1:0]        rx_data,
	output logic                          rx_valid,
	output logic                          rate_buffer_full_flag,
	output logic                          rate_buffer_empty_flag
);

	// ----------------------------------------
	// input timing
	// ----------------------------------------

	// every input comes from the pcs on ref_clk, so no synchroniser is placed:
	// one would delay the status against the word it belongs to
	// configuration inputs are expected to change only while the link is idle

	// ----------------------------------------
	// status code selection
	// ----------------------------------------

	logic [1:0]        code;
	logic              is_empty;
	logic              coded;
	logic              flagged;
	logic [SLICES-1:0] put;
	logic [DATA_W-1:0] base;
	logic [DATA_W-1:0] merged;

	// full outranks empty, which outranks the insert and delete events
	always_comb begin
		code     = `RM_CODE_NONE;
		is_empty = 1'b0;
		if (buf_full) begin
			code = `RM_CODE_FULL;
		end else if (buf_empty) begin
			code     = `RM_CODE_EMPTY;
			is_empty = 1'b1;
		end else if (buf_insert) begin
			code = `RM_CODE_INSERT;
		end else if (buf_delete) begin
			code = `RM_CODE_DELETE;
		end
	end

	// ----------------------------------------
	// placement of the code
	// ----------------------------------------

	// flag protocols never code status into the bus, so the data stays clean
	assign flagged = (proto == rate_match_pkg::proto_flag_dw);
	assign coded   = simple_if_en && status_en && !flagged;

	// pick the slice that carries the pair
	// the four slices cover every status_slice index, so no index leaves the code unplaced
	always_comb begin
		put = '0;
		if (coded) begin
			if (proto == rate_match_pkg::proto_coded_dw) begin
				put[status_slice] = 1'b1;
			end else if (wide_fabric) begin
				put[`RM_WIDE_SLICE] = 1'b1;	// pair 46:45
			end else begin
				put[`RM_NARROW_SLICE] = 1'b1;	// pair 14:13
			end
		end
	end

	// an empty word carries a pad or bad-end character in the low byte lane
	// the character is written before the merge, so the pair above it always wins
	always_comb begin
		base = pcs_data;
		if (coded && is_empty) begin
			if (empty_use_bad_end) begin
				base[`RM_CHAR_WIDTH-1:0] = `RM_BAD_END_CHAR;
			end else begin
				base[`RM_CHAR_WIDTH-1:0] = `RM_PAD_CHAR;
			end
		end
	end

	// one merge per 16-bit slice
	genvar gi;
	generate
		for (gi = 0; gi < SLICES; gi++) begin : g_slice
			rate_match_slice #(
				.W (`RM_SLICE_WIDTH)
			) rate_match_slice_inst (
				.data_in  (base[gi*`RM_SLICE_WIDTH +: `RM_SLICE_WIDTH]),
				.put_code (put[gi]),
				.code     (code),
				.data_out (merged[gi*`RM_SLICE_WIDTH +: `RM_SLICE_WIDTH])
			);
		end
	endgenerate

	// ----------------------------------------
	// output registers
	// ----------------------------------------

	// each output group keeps its own next-value logic and register, so a
	// change to one group cannot disturb the hold behaviour of another

	logic [DATA_W-1:0] data_d;
	logic [DATA_W-1:0] data_q;
	logic              valid_d;
	logic              valid_q;
	logic              full_d;
	logic              full_q;
	logic              empty_d;
	logic              empty_q;

	// ----------------------------------------
	// merged word register
	// ----------------------------------------

	// the buffer decides insert and delete timing within gaps; we only report it
	always_comb begin
		data_d = data_q;	// clk_en low freezes the word
		if (clk_en) begin
			data_d = merged;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_q <= '0;
		end else begin
			data_q <= data_d;
		end
	end

	// ----------------------------------------
	// word qualifier register
	// ----------------------------------------

	// the qualifier travels with its word so the fabric never pairs a word
	// with the qualifier of its neighbour
	always_comb begin
		valid_d = valid_q;
		if (clk_en) begin
			valid_d = pcs_valid;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= valid_d;
		end
	end

	// ----------------------------------------
	// dedicated full and empty flags
	// ----------------------------------------

	// flags stay low for coded protocols so the fabric never sees status twice;
	// they ignore the interface enables since the flag ports stand on their own
	always_comb begin
		full_d  = full_q;
		empty_d = empty_q;
		if (clk_en) begin
			full_d  = flagged && buf_full;
			empty_d = flagged && buf_empty;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			full_q  <= 1'b0;
			empty_q <= 1'b0;
		end else begin
			full_q  <= full_d;
			empty_q <= empty_d;
		end
	end

	// ----------------------------------------
	// outputs straight from the registers
	// ----------------------------------------

	assign rx_data                = data_q;
	assign rx_valid               = valid_q;
	assign rate_buffer_full_flag  = full_q;
	assign rate_buffer_empty_flag = empty_q;

endmodule : rate_match_status_mapping

/* rate_match_status_mapping_test.sv */
// self-checking bench for the rate-match status mapping block
`timescale 1ns/10ps
module rate_match_status_mapping_test;
	logic ref_clk = 0, arst_n = 0, clk_en = 0, simple_if_en = 0, status_en = 0, wide_fabric = 0;
	logic empty_use_bad_end = 0, pcs_valid = 0, buf_full = 0, buf_empty = 0;
	logic buf_insert = 0, buf_delete = 0, rx_valid, full_flag, empty_flag, got, v = 0;
	rate_match_pkg::proto_type proto = rate_match_pkg::proto_coded_dw;
	logic [1:0] status_slice = 2'h0;
	logic [63:0] pcs_data = 64'h0, rx_data;
	logic [65:0] seen, e, exp_q[$];
	logic [31:0] r;
	integer seed = 32'h2cf4, mismatches = 0, compares = 0, cycles = 0, p;
	always #2.5 ref_clk = ~ref_clk;
	rate_match_status_mapping rate_match_status_mapping_inst (.*,
		.rate_buffer_full_flag(full_flag), .rate_buffer_empty_flag(empty_flag));
	fabric_sink fabric_sink_inst (.ref_clk, .rx_valid, .full_flag, .empty_flag, .rx_data,
		.got, .seen);
	task check(input logic [65:0] seen_v, exp_v);
		compares++;
		if (seen_v !== exp_v) begin
			mismatches++;
			$display("wrong value rx word: expected %h seen %h", exp_v, seen_v);
		end
	endtask : check
	task end_sim;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	// oldest note against each captured word; a hang is cut short
	always @(negedge ref_clk) if (got) check(seen, exp_q.pop_front());
	always @(negedge ref_clk) if (++cycles == 2000) begin
		mismatches++;
		end_sim();
	end
	// random words and events; a held clk_en repeats the last word
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 arst_n = 1;
		for (int i = 0; i < 400; i++) begin
			@(posedge ref_clk) #1;
			r = $random(seed);
			proto = rate_match_pkg::proto_type'(r[1:0] == 2'h3 ? 2'h2 : r[1:0]);
			{simple_if_en, status_en} = {r[2] | r[3], r[4] | r[5]};
			{wide_fabric, status_slice, empty_use_bad_end, pcs_valid} = r[10:6];
			{buf_full, buf_empty, buf_insert, buf_delete} = r[14:11] & r[18:15];
			clk_en = !(r[19] & r[20] & r[21]);
			pcs_data = {$random(seed), $random(seed)};
			if (clk_en) begin
				e = {proto == 2'h1 ? {buf_full, buf_empty} : 2'h0, pcs_data};
				if (simple_if_en && status_en && proto != 2'h1) begin
					p = proto == 2'h0 ? 16 * status_slice + 13 : (wide_fabric ? 45 : 13);
					e[p +: 2] = buf_full ? 2'h3 : (buf_empty | buf_insert) ? 2'h2 : {1'b0, buf_delete};
					if (!buf_full && buf_empty) e[8:0] = empty_use_bad_end ? 9'h1FE : 9'h1F7;
				end
				v = pcs_valid;
			end
			if (v) exp_q.push_back(e);
		end
		// drop the qualifier so the held inputs are not reported once more
		@(posedge ref_clk) #1;
		{clk_en, pcs_valid} = 2'h2;
		repeat (4) @(posedge ref_clk);
		check(66'(exp_q.size()), 66'h0);
		end_sim();
	end
endmodule : rate_match_status_mapping_test

/* rm_chk_sva.sv */
// checker for the rate-match status mapping ports
`timescale 1ns/10ps
module rm_chk #(parameter int DATA_W = 64) (
	input wire logic ref_clk, arst_n, clk_en, simple_if_en, status_en, wide_fabric,
	input wire logic empty_use_bad_end, buf_full, buf_empty, buf_insert, buf_delete,
	input wire rate_match_pkg::proto_type proto,
	input wire logic [1:0] status_slice,
	input wire logic [DATA_W-1:0] pcs_data, rx_data,
	input wire logic rate_buffer_full_flag, rate_buffer_empty_flag);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// lo: code bound for pair 14:13; calm: no full, empty or insert
	wire on = clk_en & simple_if_en & status_en & (proto != 2'h1);
	wire lo = on & (proto == 2'h2) & !wide_fabric;
	wire calm = !buf_full & !buf_empty & !buf_insert;
	a_full_slice: assert property (
		on && proto == 2'h0 && buf_full && status_slice == 2'h1 |=> rx_data[30:29] == 2'h3)
		else $error("full code misplaced");
	a_full_wide: assert property (
		on && proto == 2'h2 && wide_fabric && buf_full |=> rx_data[46:45] == 2'h3)
		else $error("wide full code wrong");
	a_empty_char: assert property (
		on && !buf_full && buf_empty
		|=> rx_data[8:0] == ($past(empty_use_bad_end) ? 9'h1FE : 9'h1F7))
		else $error("empty character wrong");
	a_insert_code: assert property (
		lo && !buf_full && !buf_empty && buf_insert |=> rx_data[14:13] == 2'h2)
		else $error("insert code wrong");
	a_delete_code: assert property (
		lo && calm && buf_delete |=> rx_data[14:13] == 2'h1) else $error("delete code wrong");
	a_idle_code: assert property (
		lo && calm && !buf_delete |=> rx_data[14:13] == 2'h0) else $error("idle code wrong");
	a_pass_thru: assert property (
		clk_en && !(simple_if_en && status_en) |=> rx_data == $past(pcs_data))
		else $error("word altered while coding off");
	a_flag_pair: assert property (
		clk_en |=> {rate_buffer_full_flag, rate_buffer_empty_flag} == ($past(proto) == 2'h1
		? {$past(buf_full), $past(buf_empty)} : 2'h0)) else $error("flag pair wrong");
	c_full: cover property (on && buf_full);
	c_empty: cover property (on && buf_empty && !buf_full);
	c_flags: cover property (clk_en && proto == 2'h1 && buf_empty);
endmodule : rm_chk
bind rate_match_status_mapping rm_chk #(.DATA_W(DATA_W)) rm_chk_inst (.*);
